// ### hdl/srsr_host.sv
// host end: spi master issuing read, fast read and id read commands
`timescale 1ns/1ps
`default_nettype none
module srsr_host (
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [7:0] req_cmd,
   input wire logic [23:0] req_addr,
   input wire logic [7:0] req_len,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic done,
   srsr_if.host link
);
   logic miso_s1_r, miso_s2_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         miso_s1_r <= 1'b1;
         miso_s2_r <= 1'b1;
      end else begin
         miso_s1_r <= link.miso;
         miso_s2_r <= miso_s1_r;
      end
   end
   logic busy_r, busy_nxt, sclk_r, sclk_nxt, mosi_r, mosi_nxt;
   logic [3:0] div_r, div_nxt, half_r, half_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [2:0] hdr_r, hdr_nxt;
   logic [7:0] left_r, left_nxt;
   logic [39:0] tx_r, tx_nxt;
   logic [7:0] rx_r, rx_nxt;
   logic rv_r, rv_nxt, done_r, done_nxt;
   assign req_ready = !busy_r;
   always_comb begin
      busy_nxt = busy_r;
      sclk_nxt = sclk_r;
      mosi_nxt = mosi_r;
      div_nxt = div_r;
      half_nxt = half_r;
      bit_nxt = bit_r;
      hdr_nxt = hdr_r;
      left_nxt = left_r;
      tx_nxt = tx_r;
      rx_nxt = rx_r;
      rv_nxt = 1'b0;
      done_nxt = 1'b0;
      if (!busy_r) begin
         if (req_valid) begin
            busy_nxt = 1'b1;
            tx_nxt = {req_cmd, req_addr, 8'h00};
            mosi_nxt = req_cmd[7];
            hdr_nxt = (req_cmd == srsr_pkg::CMD_FAST_READ) ? 3'd5
                    : (req_cmd == srsr_pkg::CMD_READ) ? 3'd4 : 3'd1;
            half_nxt = (req_cmd == srsr_pkg::CMD_FAST_READ) ? 4'(srsr_pkg::HALF_FAST_CYC)
                     : 4'(srsr_pkg::HALF_READ_CYC);
            left_nxt = req_len;
            div_nxt = 4'd0;
            bit_nxt = 3'd0;
         end
      end else if (div_r + 4'd1 >= half_r) begin
         div_nxt = 4'd0;
         sclk_nxt = !sclk_r;
         if (!sclk_r) begin
            rx_nxt = {rx_r[6:0], miso_s2_r};
            if (bit_r == srsr_pkg::BIT_LAST && hdr_r == 3'd0) begin
               rv_nxt = 1'b1;
               left_nxt = left_r - 8'd1;
            end
         end else begin
            bit_nxt = bit_r + 3'd1;
            tx_nxt = {tx_r[38:0], 1'b0};
            mosi_nxt = tx_r[38];
            if (bit_r == srsr_pkg::BIT_LAST) begin
               if (hdr_r != 3'd0) begin
                  hdr_nxt = hdr_r - 3'd1;
               end
               if ((hdr_r == 3'd0 || (hdr_r == 3'd1 && left_r == 8'd0)) && left_r == 8'd0) begin
                  busy_nxt = 1'b0;
                  done_nxt = 1'b1;
               end
            end
         end
      end else begin
         div_nxt = div_r + 4'd1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_r <= 1'b0;
         sclk_r <= 1'b0;
         mosi_r <= 1'b0;
         div_r <= 4'd0;
         half_r <= 4'd1;
         bit_r <= 3'd0;
         hdr_r <= 3'd0;
         left_r <= 8'd0;
         tx_r <= 40'h00_0000_0000;
         rx_r <= 8'h00;
         rv_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
         sclk_r <= sclk_nxt;
         mosi_r <= mosi_nxt;
         div_r <= div_nxt;
         half_r <= half_nxt;
         bit_r <= bit_nxt;
         hdr_r <= hdr_nxt;
         left_r <= left_nxt;
         tx_r <= tx_nxt;
         rx_r <= rx_nxt;
         rv_r <= rv_nxt;
         done_r <= done_nxt;
      end
   end
   assign link.cs_n = !busy_r;
   assign link.sclk = sclk_r;
   assign link.mosi = mosi_r;
   assign rd_valid = rv_r;
   assign rd_data = rx_r;
   assign done = done_r;
endmodule : srsr_host
`default_nettype wire

// ### hdl/srsr_if.sv
// interface: spi pins between host and rom
`timescale 1ns/1ps
`default_nettype none
interface srsr_if;
   logic cs_n;
   logic sclk;
   logic mosi;
   logic miso_o;
   logic miso_oe_n;
   logic miso;
   assign miso = miso_oe_n ? 1'b1 : miso_o;
   modport rom (input cs_n, input sclk, input mosi, output miso_o, output miso_oe_n);
   modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : srsr_if
`default_nettype wire

// ### hdl/srsr_pkg.sv
// package: commands, identity codes and timing for the serial rom read link
package srsr_pkg;
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_FAST_READ = 8'h0B;
   localparam logic [7:0] IDENTIFICATION_READ_CMD = 8'h9F;
   // identity values are arbitrary
   localparam logic [7:0] ID_MANUFACTURER = 8'h5A;
   localparam logic [7:0] ID_TYPE = 8'h3C;
   localparam logic [7:0] ID_CAPACITY = 8'h18;
   localparam int ADDR_W = 24;
   localparam int ADDR_BYTES = 3;
   localparam int ID_BYTES = 3;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_ZERO = 3'h0;
   // link clock half period for the host divider
   localparam real SCLK_READ_MHZ = 20.0;
   localparam real SCLK_FAST_MHZ = 33.0;
   localparam real CLK_MHZ = 100.0;
   // rom input sync, output register and host sync take five clocks per turn, so a half period needs six
   localparam int HALF_MIN_CYC = 6;
   localparam int HALF_READ_RATE = int'($ceil(CLK_MHZ / (2.0 * SCLK_READ_MHZ)));
   localparam int HALF_FAST_RATE = int'($ceil(CLK_MHZ / (2.0 * SCLK_FAST_MHZ)));
   localparam int HALF_READ_CYC = (HALF_READ_RATE > HALF_MIN_CYC) ? HALF_READ_RATE : HALF_MIN_CYC;
   localparam int HALF_FAST_CYC = (HALF_FAST_RATE > HALF_MIN_CYC) ? HALF_FAST_RATE : HALF_MIN_CYC;
   typedef enum logic [2:0] {
      ST_CMD = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_DATA = 3'b011,
      ST_ID = 3'b100,
      ST_STANDBY = 3'b101
   } srsr_state_t;
endpackage : srsr_pkg

// ### hdl/srsr_rom.sv
// rom end: serial read-only memory responding to read, fast read and id read
// Notes on behaviour
// - read is 0x03 then three address bytes
// - address sent high byte first
// - data streams until chip select rises
// - fast read adds one ignored dummy byte
// - id read 0x9F returns three bytes
// - id order: maker, type, capacity constants
// - first byte after select is command
// - read commands stay active until deselect
// - unknown command: standby until next select
// - output floats during standby
// - deselect enters standby on rising edge
// - bad command: standby at the eighth rise that completes it
// - output bits change on falling edge
// - input sampled on rising clock edge
// - all bytes most significant bit first
// - fixed read-only array, no writes
// - host keeps clock within rate limits
// - output starts in last input bit0
`timescale 1ns/1ps
`default_nettype none
module srsr_rom #(
   parameter int MEM_ADDR_W = 10
) (
   input wire logic clk,
   input wire logic rst,
   srsr_if.rom link
);
   logic [7:0] mem [0:(1 << MEM_ADDR_W) - 1];
   // fixed content pattern stands for the factory image
   always_comb begin
      for (int i = 0; i < (1 << MEM_ADDR_W); i++) begin
         mem[i] = i[7:0] ^ 8'hA5;
      end
   end
   logic cs_s1_r, cs_s2_r, ck_s1_r, ck_s2_r, ck_s3_r, di_s1_r, di_s2_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         ck_s1_r <= 1'b0;
         ck_s2_r <= 1'b0;
         ck_s3_r <= 1'b0;
         di_s1_r <= 1'b0;
         di_s2_r <= 1'b0;
      end else begin
         cs_s1_r <= link.cs_n;
         cs_s2_r <= cs_s1_r;
         ck_s1_r <= link.sclk;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
         di_s1_r <= link.mosi;
         di_s2_r <= di_s1_r;
      end
   end
   logic rise, fall;
   assign rise = ck_s2_r & ~ck_s3_r;
   assign fall = ~ck_s2_r & ck_s3_r;

   srsr_pkg::srsr_state_t st_r, st_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [srsr_pkg::ADDR_W-1:0] addr_r, addr_nxt;
   logic [7:0] out_r, out_nxt;
   logic do_r, do_nxt;
   logic oe_n_r, oe_n_nxt;
   logic load_r, load_nxt;
   logic [7:0] inbyte;
   logic [7:0] idb;
   logic [srsr_pkg::ADDR_W-1:0] addr_full;

   assign inbyte = {sh_r[6:0], di_s2_r};
   assign addr_full = {addr_r[15:0], inbyte};
   // byte that follows the one now leaving
   always_comb begin
      unique case (cnt_r)
         2'd0: idb = srsr_pkg::ID_TYPE;
         2'd1: idb = srsr_pkg::ID_CAPACITY;
         default: idb = 8'h00;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      bit_nxt = bit_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      addr_nxt = addr_r;
      out_nxt = out_r;
      do_nxt = do_r;
      oe_n_nxt = oe_n_r;
      load_nxt = load_r;
      if (cs_s2_r) begin
         // deselect abandons everything; standby taken at once
         st_nxt = srsr_pkg::ST_CMD;
         bit_nxt = 3'h0;
         cnt_nxt = 2'd0;
         oe_n_nxt = 1'b1;
         load_nxt = 1'b0;
      end else if (rise) begin
         sh_nxt = inbyte;
         bit_nxt = bit_r + 3'h1;
         if (bit_r == srsr_pkg::BIT_LAST) begin
            unique case (st_r)
               srsr_pkg::ST_CMD: begin
                  cnt_nxt = 2'd0;
                  if (inbyte == srsr_pkg::CMD_READ || inbyte == srsr_pkg::CMD_FAST_READ) begin
                     st_nxt = srsr_pkg::ST_ADDR;
                     load_nxt = inbyte == srsr_pkg::CMD_FAST_READ;
                  end else if (inbyte == srsr_pkg::IDENTIFICATION_READ_CMD) begin
                     st_nxt = srsr_pkg::ST_ID;
                     out_nxt = srsr_pkg::ID_MANUFACTURER;
                  end else begin
                     st_nxt = srsr_pkg::ST_STANDBY;
                     oe_n_nxt = 1'b1;
                  end
               end
               srsr_pkg::ST_ADDR: begin
                  addr_nxt = {addr_r[15:0], inbyte};
                  cnt_nxt = cnt_r + 2'd1;
                  if (cnt_r == 2'(srsr_pkg::ADDR_BYTES - 1)) begin
                     cnt_nxt = 2'd0;
                     st_nxt = load_r ? srsr_pkg::ST_DUMMY : srsr_pkg::ST_DATA;
                     out_nxt = mem[addr_full[MEM_ADDR_W-1:0]];
                  end
               end
               srsr_pkg::ST_DUMMY: st_nxt = srsr_pkg::ST_DATA;
               srsr_pkg::ST_DATA: begin
                  addr_nxt = addr_r + 24'h00_0001;
                  out_nxt = mem[addr_nxt[MEM_ADDR_W-1:0]];
               end
               srsr_pkg::ST_ID: begin
                  cnt_nxt = (cnt_r == 2'(srsr_pkg::ID_BYTES - 1)) ? cnt_r : cnt_r + 2'd1;
                  out_nxt = idb;
               end
               default: ;
            endcase
         end
      end else if (fall) begin
         // output states are entered on the last header rise, so their first fall opens bit 0 with the out_r msb
         if (st_r == srsr_pkg::ST_DATA || st_r == srsr_pkg::ST_ID) begin
            oe_n_nxt = 1'b0;
            do_nxt = out_r[3'h7 - bit_r];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= srsr_pkg::ST_CMD;
         bit_r <= 3'h0;
         cnt_r <= 2'd0;
         sh_r <= 8'h00;
         addr_r <= 24'h00_0000;
         out_r <= 8'h00;
         do_r <= 1'b0;
         oe_n_r <= 1'b1;
         load_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         bit_r <= bit_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         addr_r <= addr_nxt;
         out_r <= out_nxt;
         do_r <= do_nxt;
         oe_n_r <= oe_n_nxt;
         load_r <= load_nxt;
      end
   end
   assign link.miso_o = do_r;
   assign link.miso_oe_n = oe_n_r;
endmodule : srsr_rom
`default_nettype wire

// ### test/serial_rom_spi_read_tb.sv
// testbench: host and rom joined over the spi link
`timescale 1ns/1ps
`default_nettype none
module serial_rom_spi_read_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic req_ready;
   logic [7:0] req_cmd = 8'h00;
   logic [23:0] req_addr = 24'h00_0000;
   logic [7:0] req_len = 8'h00;
   logic rd_valid;
   logic [7:0] rd_data;
   logic done;
   logic [7:0] exp_q[$];
   int bad_count = 0;
   int n_compared = 0;
   srsr_if ifc ();
   srsr_rom srsr_rom_i (.clk(clk), .rst(rst), .link(ifc));
   srsr_host srsr_host_i (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
      .req_addr(req_addr), .req_len(req_len), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .link(ifc));
   srsr_properties srsr_properties_i (.clk(clk), .rst(rst), .cs_n(ifc.cs_n), .sclk(ifc.sclk), .mosi(ifc.mosi),
      .miso_o(ifc.miso_o), .miso_oe_n(ifc.miso_oe_n));
   always #5 clk = ~clk;
   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   task automatic fail(input string msg);
      bad_count++;
      $display("Error at %0t: %s", $time, msg);
   endtask : fail
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
   endtask : check
   // one host request; every returned byte is matched against exp_q in order
   task automatic xfer(input logic [7:0] cmd, input logic [23:0] addr, input logic [7:0] len);
      int n;
      @(negedge clk);
      req_cmd = cmd;
      req_addr = addr;
      req_len = len;
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n >= 100) begin
         fail("request not accepted");
         end_sim();
      end
      @(posedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      n = 0;
      while (n < 4000) begin
         @(posedge clk);
         #1;
         if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected byte");
            else check(rd_data, exp_q.pop_front());
         end
         if (done === 1'b1) break;
         n++;
      end
      if (n >= 4000) begin
         fail("transfer did not finish");
         end_sim();
      end
      n_compared++;
      if (exp_q.size() != 0) fail("bytes missing");
   endtask : xfer
   // read across a 256-byte boundary
   task automatic read_wrap;
      for (int i = 0; i < 4; i++) exp_q.push_back(8'(8'hFE + i) ^ 8'hA5);
      xfer(srsr_pkg::CMD_READ, 24'h12_34FE, 8'h04);
   endtask : read_wrap
   task automatic fast_read;
      for (int i = 0; i < 3; i++) exp_q.push_back(8'(8'h40 + i) ^ 8'hA5);
      xfer(srsr_pkg::CMD_FAST_READ, 24'h00_0040, 8'h03);
   endtask : fast_read
   task automatic id_read;
      exp_q.push_back(srsr_pkg::ID_MANUFACTURER);
      exp_q.push_back(srsr_pkg::ID_TYPE);
      exp_q.push_back(srsr_pkg::ID_CAPACITY);
      xfer(srsr_pkg::IDENTIFICATION_READ_CMD, 24'h00_0000, 8'h03);
   endtask : id_read
   // unknown command: floating output reads as all ones
   task automatic bad_cmd;
      exp_q.push_back(8'hFF);
      exp_q.push_back(8'hFF);
      xfer(8'h55, 24'h00_0000, 8'h02);
   endtask : bad_cmd
   task automatic read_after_bad;
      exp_q.push_back(8'h00 ^ 8'hA5);
      xfer(srsr_pkg::CMD_READ, 24'h00_0000, 8'h01);
   endtask : read_after_bad
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      read_wrap();
      fast_read();
      id_read();
      bad_cmd();
      read_after_bad();
      end_sim();
   end
endmodule : serial_rom_spi_read_tb
`default_nettype wire

// ### test/srsr_properties.sv
// checker: timing properties of the spi link between host and rom
`timescale 1ns/1ps
`default_nettype none
module srsr_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe_n
);
   logic sclk_r;
   logic [7:0] cmd_r;
   logic [7:0] rise_r;
   logic [2:0] fall_r;
   logic [7:0] hdr;
   // header length in sclk rises once the command byte is complete
   always_comb begin
      hdr = 8'h00;
      if (rise_r >= 8'h08) begin
         case (cmd_r)
            srsr_pkg::CMD_READ: hdr = 8'h20;
            srsr_pkg::CMD_FAST_READ: hdr = 8'h28;
            srsr_pkg::IDENTIFICATION_READ_CMD: hdr = 8'h08;
            default: hdr = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_r <= 1'b0;
         cmd_r <= 8'h00;
         rise_r <= 8'h00;
         fall_r <= 3'h7;
      end else if (cs_n) begin
         sclk_r <= 1'b0;
         cmd_r <= 8'h00;
         rise_r <= 8'h00;
         fall_r <= 3'h7;
      end else begin
         sclk_r <= sclk;
         if (sclk && !sclk_r && rise_r < 8'h08) cmd_r <= {cmd_r[6:0], mosi};
         if (sclk && !sclk_r && rise_r != 8'hFF) rise_r <= rise_r + 8'h01;
         if (!sclk && sclk_r) fall_r <= 3'h0;
         else if (fall_r != 3'h7) fall_r <= fall_r + 3'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_float_deselect: assert property (cs_n [*6] |-> miso_oe_n)
      else $error("output driven while deselected");
   a_no_early_drive: assert property ((!cs_n) [*8] ##0 !miso_oe_n |-> hdr != 8'h00 && rise_r >= hdr)
      else $error("output driven before header done");
   a_drive_start: assert property ($fell(sclk) && !cs_n && hdr != 8'h00 && rise_r == hdr |-> ##[1:5] !miso_oe_n)
      else $error("output not driven in last header bit");
   a_keep_active: assert property ((!cs_n) [*5] ##0 !miso_oe_n |=> !miso_oe_n || cs_n)
      else $error("output dropped while selected");
   a_bad_cmd_float: assert property (!cs_n && rise_r >= 8'h09 && hdr == 8'h00 |-> miso_oe_n)
      else $error("output driven after unknown command");
   a_out_on_fall: assert property (!miso_oe_n && $past(!miso_oe_n) && $changed(miso_o) |-> fall_r <= 3'h4)
      else $error("output changed away from falling edge");
   a_mosi_stable: assert property ($rose(sclk) && !cs_n |-> $stable(mosi))
      else $error("input changed at rising edge");
   a_sclk_high: assert property ($rose(sclk) |=> sclk)
      else $error("serial clock high too short");
   a_sclk_low: assert property ($fell(sclk) && !cs_n |=> !sclk)
      else $error("serial clock low too short");
endmodule : srsr_properties
`default_nettype wire
